/* File: src/ofd_decoder.sv */
// operand field decoder with ahb-lite register slave
`timescale 1ns/10ps
module ofd_decoder (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  output logic [11:0] eff_addr_o,
  output logic [7:0] bit_mask_o,
  output logic result_to_acc_o,
  output logic shadow_sel_o,
  output logic [19:0] literal_o,
  output logic busy_o
);
  import ofd_pkg::*;

  // ****************************************
  // functions
  // ****************************************
  // short address plus access bit and bank to a 12-bit file address
  function automatic logic [11:0] file_addr(input logic acc_bit,
      input logic [7:0] f, input logic [3:0] bank);
    logic [3:0] hi;
    hi = (f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK;
    return {acc_bit ? bank : hi, f}; // access ram ignores the bank
  endfunction : file_addr

  // sign-extend an 11-bit displacement to a 21-bit word step
  function automatic logic [20:0] rel_step(input logic [10:0] n);
    return {{9{n[10]}}, n, 1'b0};
  endfunction : rel_step

  // ****************************************
  // state
  // ****************************************
  ofd_state_t state_q;
  logic [3:0] class_q;
  logic [15:0] instr0_q, instr1_q;
  logic [3:0] bank_q;
  logic [7:0] acc_q;
  logic [4:0] flags_q;
  logic [20:0] pc_q, ret_q, table_pointer_q, tbl_addr_q;
  logic [7:0] lath_q, table_latch_q, multiply_product_high_q, multiply_product_low_q;
  logic [4:0] latu_q;
  logic [7:0] sh_acc_q;
  logic [4:0] sh_flags_q;
  logic [3:0] sh_bank_q;
  logic [31:0] addr_q;
  logic wr_q;
  logic [7:0] rdata_w;

  // ****************************************
  // bus decode
  // ****************************************
  // address phase accepted and data phase write strobes
  wire addr_ok_w = hsel_i & htrans_i[1] & hready_i;
  wire bwr_w = wr_q;
  wire wr_class_w = bwr_w & (addr_q == A_CLASS);
  wire wr_instr0_w = bwr_w & (addr_q == A_INSTR0);
  wire wr_instr1_w = bwr_w & (addr_q == A_INSTR1);
  wire wr_bank_w = bwr_w & (addr_q == A_BANK);
  wire wr_acc_w = bwr_w & (addr_q == A_ACC);
  wire wr_exec_w = bwr_w & (addr_q == A_EXEC);
  wire wr_flags_w = bwr_w & (addr_q == A_FLAGS);
  wire wr_pc_w = bwr_w & (addr_q == A_PC);
  wire wr_lath_w = bwr_w & (addr_q == A_LATH);
  wire wr_latu_w = bwr_w & (addr_q == A_LATU);
  wire wr_table_pointer_w = bwr_w & (addr_q == A_TABLE_POINTER);
  wire wr_table_latch_w = bwr_w & (addr_q == A_TABLE_LATCH);
  wire exec_go_w = wr_exec_w & (state_q == S_IDLE);

  // ****************************************
  // field decode
  // ****************************************
  // only documented fields are looked at; other bits are ignored
  wire [7:0] f_w = instr0_q[POS_F +: 8];
  wire a_w = instr0_q[POS_A];
  wire d_w = instr0_q[POS_D];
  wire [2:0] bit_w = instr0_q[POS_BIT +: 3];
  wire s_w = instr0_q[POS_S];
  wire [1:0] mm_w = instr0_q[POS_MM +: 2];
  wire [10:0] n_w = instr0_q[POS_N +: 11];
  wire [11:0] fs_w = instr0_q[POS_FILE12 +: 12];
  wire [11:0] fd_w = instr1_q[POS_FILE12 +: 12];
  wire [11:0] ea_w = file_addr(a_w, f_w, bank_q);
  wire [7:0] mask_w = 8'h01 << bit_w;
  wire is_move_w = (class_q == CLS_MOVE);
  wire [11:0] src_w = is_move_w ? fs_w : ea_w;
  wire [7:0] k8_w = instr0_q[7:0];
  wire [11:0] k12_w = {instr0_q[3:0], instr1_q[7:0]};
  wire [19:0] k20_w = {instr1_q[11:0], instr0_q[7:0]};

  // literal width chosen by instruction class
  wire [19:0] lit_w = (class_q == CLS_LIT12) ? {8'h00, k12_w} :
                      (class_q == CLS_GOTO || class_q == CLS_CALL) ? k20_w :
                      {12'h000, k8_w};

  // ****************************************
  // execution datapath
  // ****************************************
  // add of accumulator and file byte with all five flags
  wire [8:0] sum_w = {1'b0, acc_q} + {1'b0, rdata_w};
  wire [4:0] nib_w = {1'b0, acc_q[3:0]} + {1'b0, rdata_w[3:0]};
  wire ov_w = (acc_q[7] == rdata_w[7]) & (sum_w[7] != acc_q[7]);
  wire [4:0] add_flags_w = {sum_w[7], ov_w, (sum_w[7:0] == 8'h00),
                            nib_w[4], sum_w[8]};
  wire [15:0] prod_w = {8'h00, acc_q} * {8'h00, k8_w};
  wire exe_w = (state_q == S_EXE);

  // file memory write: which class writes what and where
  wire ram_we_w = exe_w & (((class_q == CLS_BYTE) & d_w) |
                  (class_q == CLS_BIT) | (class_q == CLS_STORE) |
                  is_move_w);
  wire [11:0] ram_waddr_w = is_move_w ? fd_w : ea_w;
  wire [7:0] ram_wdata_w = (class_q == CLS_BYTE) ? sum_w[7:0] :
                           (class_q == CLS_BIT) ? (rdata_w | mask_w) :
                           (class_q == CLS_STORE) ? acc_q : rdata_w;

  // table pointer step and accessed address by mode
  wire [20:0] ptr_inc_w = table_pointer_q + 21'h00_0001;
  wire [20:0] ptr_dec_w = table_pointer_q - 21'h00_0001;
  wire [20:0] ptr_next_w = (mm_w == MM_NONE) ? table_pointer_q :
                           (mm_w == MM_POST_DEC) ? ptr_dec_w :
                           ptr_inc_w;
  wire [20:0] ptr_use_w = (mm_w == MM_PRE_INC) ? ptr_inc_w : table_pointer_q;

  // branch targets: relative displacement or direct word address
  wire [20:0] rel_tgt_w = pc_q + PC_STEP + rel_step(n_w);
  wire [20:0] abs_tgt_w = {k20_w, 1'b0};

  ofd_file_ram u_ram (
    .clk_sys_i(clk_sys_i),
    .raddr_i(src_w),
    .rdata_o(rdata_w),
    .we_i(ram_we_w),
    .waddr_i(ram_waddr_w),
    .wdata_i(ram_wdata_w)
  );

  // ****************************************
  // read mux
  // ****************************************
  wire [31:0] rd_mux_w =
    (haddr_i == A_CLASS) ? {28'h0, class_q} :
    (haddr_i == A_INSTR0) ? {16'h0, instr0_q} :
    (haddr_i == A_INSTR1) ? {16'h0, instr1_q} :
    (haddr_i == A_BANK) ? {28'h0, bank_q} :
    (haddr_i == A_ACC) ? {24'h0, acc_q} :
    (haddr_i == A_EXEC) ? {31'h0, state_q != S_IDLE} :
    (haddr_i == A_FLAGS) ? {27'h0, flags_q} :
    (haddr_i == A_FADDR) ? {4'h0, fd_w, 4'h0, src_w} :
    (haddr_i == A_FIELDS) ? {16'h0, mask_w, s_w, mm_w, bit_w, d_w, a_w} :
    (haddr_i == A_LIT) ? {12'h0, lit_w} :
    (haddr_i == A_PC) ? {11'h0, pc_q} :
    (haddr_i == A_LATH) ? {24'h0, lath_q} :
    (haddr_i == A_LATU) ? {27'h0, latu_q} :
    (haddr_i == A_TABLE_POINTER) ? {11'h0, table_pointer_q} :
    (haddr_i == A_TABLE_LATCH) ? {24'h0, table_latch_q} :
    (haddr_i == A_PROD) ? {16'h0, multiply_product_high_q, multiply_product_low_q} :
    (haddr_i == A_ID_LOW) ? {24'h0, PART_ID_LOWER, PART_REV} :
    (haddr_i == A_ID_HIGH) ? {24'h0, PART_ID_UPPER} :
    32'h0000_0000;

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign busy_o = (state_q != S_IDLE);

  // ****************************************
  // bus phase registers
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      addr_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      hrdata_o <= 32'h0000_0000;
    end else begin
      addr_q <= haddr_i;
      wr_q <= addr_ok_w & hwrite_i;
      hrdata_o <= (addr_ok_w & ~hwrite_i) ? rd_mux_w : 32'h0000_0000;
    end
  end

  // ****************************************
  // decoded output registers
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      eff_addr_o <= 12'h000;
      bit_mask_o <= 8'h01;
      result_to_acc_o <= 1'b1;
      shadow_sel_o <= 1'b0;
      literal_o <= 20'h0_0000;
    end else begin
      eff_addr_o <= src_w;
      bit_mask_o <= mask_w;
      result_to_acc_o <= ~d_w;
      shadow_sel_o <= s_w;
      literal_o <= lit_w;
    end
  end

  // ****************************************
  // execution sequencer
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: state_q <= exec_go_w ? S_READ : S_IDLE;
        S_READ: state_q <= S_EXE;
        S_EXE: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // architectural registers; a bus write wins over execution
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      class_q <= 4'h0;
      instr0_q <= RST_WORD;
      instr1_q <= RST_WORD;
      bank_q <= 4'h0;
      acc_q <= RST_BYTE;
      flags_q <= 5'h00;
      pc_q <= RST_PTR;
      ret_q <= RST_PTR;
      lath_q <= RST_BYTE;
      latu_q <= 5'h00;
      table_pointer_q <= RST_PTR;
      tbl_addr_q <= RST_PTR;
      table_latch_q <= RST_BYTE;
      multiply_product_high_q <= RST_BYTE;
      multiply_product_low_q <= RST_BYTE;
      sh_acc_q <= RST_BYTE;
      sh_flags_q <= 5'h00;
      sh_bank_q <= 4'h0;
    end else begin
      if (exe_w) begin
        case (class_q)
          CLS_BYTE: begin
            flags_q <= add_flags_w;
            if (!d_w) begin
              acc_q <= sum_w[7:0];
            end
          end
          CLS_LIT: acc_q <= k8_w;
          CLS_MUL: begin
            multiply_product_high_q <= prod_w[15:8];
            multiply_product_low_q <= prod_w[7:0];
          end
          CLS_TABLE: begin
            table_pointer_q <= ptr_next_w;
            tbl_addr_q <= ptr_use_w;
          end
          CLS_BRA: pc_q <= rel_tgt_w;
          CLS_GOTO: pc_q <= abs_tgt_w;
          CLS_CALL: begin
            pc_q <= abs_tgt_w;
            ret_q <= pc_q + CALL_STEP;
            if (s_w) begin
              sh_acc_q <= acc_q;
              sh_flags_q <= flags_q;
              sh_bank_q <= bank_q;
            end
          end
          CLS_RET: begin
            pc_q <= ret_q;
            if (s_w) begin
              acc_q <= sh_acc_q;
              flags_q <= sh_flags_q;
              bank_q <= sh_bank_q;
            end
          end
          default: pc_q <= pc_q;
        endcase
      end
      if (wr_class_w) class_q <= hwdata_i[3:0];
      if (wr_instr0_w) instr0_q <= hwdata_i[15:0];
      if (wr_instr1_w) instr1_q <= hwdata_i[15:0];
      if (wr_bank_w) bank_q <= hwdata_i[3:0];
      if (wr_acc_w) acc_q <= hwdata_i[7:0];
      if (wr_flags_w) flags_q <= hwdata_i[4:0];
      if (wr_lath_w) lath_q <= hwdata_i[7:0];
      if (wr_latu_w) latu_q <= hwdata_i[4:0];
      if (wr_table_pointer_w) table_pointer_q <= hwdata_i[20:0];
      if (wr_table_latch_w) table_latch_q <= hwdata_i[7:0];
      if (wr_pc_w) pc_q <= {latu_q, lath_q, hwdata_i[7:0]};
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence exec_start_s;
    exec_go_w;
  endsequence
  sequence exec_steps_s;
    ##1 (state_q == S_READ) ##1 (state_q == S_EXE) ##1 (state_q == S_IDLE);
  endsequence

  exec_sequence_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) exec_start_s |-> exec_steps_s)
    else $error("execution did not take three cycles");
  id_read_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    (addr_ok_w && !hwrite_i && haddr_i == A_ID_HIGH)
    |=> hrdata_o == {24'h0, PART_ID_UPPER})
    else $error("id register read wrong value");
  access_bank_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (!a_w && !is_move_w)
    |=> eff_addr_o[11:8] == (($past(f_w) < ACCESS_SPLIT) ?
        ACCESS_LO_BANK : ACCESS_HI_BANK))
    else $error("access bit zero did not pick access ram");
  banked_addr_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (a_w && !is_move_w)
    |=> eff_addr_o == {$past(bank_q), $past(f_w)})
    else $error("banked address not taken from bank register");
  bit_select_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    1'b1 |=> ($onehot(bit_mask_o) && bit_mask_o[$past(bit_w)]))
    else $error("bit mask does not match bit field");
  dest_acc_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    (exe_w && class_q == CLS_BYTE && !d_w && !wr_acc_w)
    |-> !ram_we_w ##1 acc_q == $past(sum_w[7:0]))
    else $error("destination zero did not go to accumulator");
  move_dest_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (exe_w && is_move_w)
    |-> (ram_we_w && ram_waddr_w == fd_w && ram_wdata_w == rdata_w))
    else $error("move not written to destination address");
  pc_load_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) wr_pc_w
    |=> pc_q == {$past(latu_q), $past(lath_q), $past(hwdata_i[7:0])})
    else $error("counter low write did not load latches");
  table_access_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (exe_w && class_q == CLS_TABLE && !wr_table_pointer_w)
    |=> tbl_addr_q == $past(table_pointer_q) +
        {20'h0_0000, $past(mm_w) == MM_PRE_INC})
    else $error("table access address wrong for its mode");
  shadow_keep_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) (exe_w && class_q == CLS_CALL && !s_w)
    |=> ($stable(sh_acc_q) && $stable(sh_flags_q) && $stable(sh_bank_q)))
    else $error("shadow registers changed without fast bit");

endmodule : ofd_decoder

/* File: src/ofd_file_ram.sv */
// data file memory: 4096 bytes, one write port, registered read
`timescale 1ns/10ps
module ofd_file_ram (
  input wire logic clk_sys_i,
  input wire logic [11:0] raddr_i,
  output logic [7:0] rdata_o,
  input wire logic we_i,
  input wire logic [11:0] waddr_i,
  input wire logic [7:0] wdata_i
);
  logic [7:0] mem [0:4095];

  // write and registered read
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : ofd_file_ram

/* File: src/ofd_pkg.sv */
// constants, register map and types of the operand field decoder
package ofd_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [31:0] A_CLASS = 32'h0000_0000;
  localparam logic [31:0] A_INSTR0 = 32'h0000_0004;
  localparam logic [31:0] A_INSTR1 = 32'h0000_0008;
  localparam logic [31:0] A_BANK = 32'h0000_000C;
  localparam logic [31:0] A_ACC = 32'h0000_0010;
  localparam logic [31:0] A_EXEC = 32'h0000_0014;
  localparam logic [31:0] A_FLAGS = 32'h0000_0018;
  localparam logic [31:0] A_FADDR = 32'h0000_001C;
  localparam logic [31:0] A_FIELDS = 32'h0000_0020;
  localparam logic [31:0] A_LIT = 32'h0000_0024;
  localparam logic [31:0] A_PC = 32'h0000_0028;
  localparam logic [31:0] A_LATH = 32'h0000_002C;
  localparam logic [31:0] A_LATU = 32'h0000_0030;
  localparam logic [31:0] A_TABLE_POINTER = 32'h0000_0034;
  localparam logic [31:0] A_TABLE_LATCH = 32'h0000_0038;
  localparam logic [31:0] A_PROD = 32'h0000_003C;
  localparam logic [31:0] A_ID_LOW = 32'h0000_0040;
  // printed offset is an index; the byte address is four times it
  localparam logic [31:0] IDX_ID_HIGH = 32'h003F_FFFF;
  localparam logic [31:0] A_ID_HIGH = {IDX_ID_HIGH[29:0], 2'b00};

  // ****************************************
  // instruction field positions
  // ****************************************
  localparam int POS_F = 0;
  localparam int POS_A = 8;
  localparam int POS_D = 9;
  localparam int POS_BIT = 9;
  localparam int POS_S = 0;
  localparam int POS_MM = 0;
  localparam int POS_FILE12 = 0;
  localparam int POS_N = 0;

  // ****************************************
  // flag bit positions, access split, reset values
  // ****************************************
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [20:0] RST_PTR = 21'h00_0000;
  localparam logic [20:0] PC_STEP = 21'h00_0002;
  localparam logic [20:0] CALL_STEP = 21'h00_0004;

  // identification values: arbitrary, neutral
  localparam logic [7:0] PART_ID_UPPER = 8'h5A;
  localparam logic [2:0] PART_ID_LOWER = 3'h2;
  localparam logic [4:0] PART_REV = 5'h01;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    CLS_BYTE, CLS_BIT, CLS_STORE, CLS_MOVE, CLS_LIT, CLS_MUL,
    CLS_LIT12, CLS_TABLE, CLS_BRA, CLS_GOTO, CLS_CALL, CLS_RET
  } ofd_class_t;
  typedef enum logic [1:0] {
    MM_NONE, MM_POST_INC, MM_POST_DEC, MM_PRE_INC
  } ofd_mm_t;
  typedef enum logic [1:0] {S_IDLE, S_READ, S_EXE} ofd_state_t;

endpackage : ofd_pkg

/* File: verification/ofd_ahb_master.sv */
// behavioural ahb-lite master standing for the core's bus side
`timescale 1ns/10ps
module ofd_ahb_master (
  input wire logic clk_sys_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o,
  output logic tmo_o
);
  // ****************************************
  // bus cycles
  // ****************************************
  // idle bus at time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
    tmo_o = 1'b0;
  end
  // wait for hready high at a rising edge; data taken at that same edge
  task automatic step(output logic [31:0] rd);
    int n;
    logic rdy;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      rdy = hready_i;
      rd = hrdata_i;
      n++;
    end while (rdy !== 1'b1 && n < 64);
    if (rdy !== 1'b1) begin
      tmo_o = 1'b1;
    end
  endtask : step
  // one single word transfer: address phase then data phase
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] dummy;
    @(posedge clk_sys_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    hwrite_o <= w;
    htrans_o <= 2'b10;
    step(dummy);
    htrans_o <= 2'b00;
    hsel_o <= 1'b0;
    hwdata_o <= w ? wd : 32'h0;
    step(rd);
  endtask : xfer
endmodule : ofd_ahb_master

/* File: verification/operand_field_decoder_bench.sv */
// self-checking bench of the operand field decoder
`timescale 1ns/10ps
module operand_field_decoder_bench;
  import ofd_pkg::*;
  typedef struct packed {
    ofd_class_t cls; logic [15:0] i0; logic [15:0] i1; logic [3:0] bk;
    logic [3:0] chk; logic [11:0] ea; logic [19:0] lit;
  } ofd_row_t;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel, hwrite, hready, hresp, to_acc, shadow, busy, tmo;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] eff_addr;
  logic [7:0] bit_mask;
  logic [19:0] literal;
  int err_count = 0;
  int tests_run = 0;
  // chk: 1 address, 2 literal, 4 fast bit, 8 bit mask and destination
  ofd_row_t rows [12] = '{
    '{CLS_BYTE, 16'h0030, 16'h0000, 4'h5, 4'h9, 12'h030, 20'h0},
    '{CLS_BYTE, 16'hF0A5, 16'h0000, 4'h5, 4'h9, 12'hFA5, 20'h0},
    '{CLS_BYTE, 16'h03FF, 16'h0000, 4'h5, 4'h9, 12'h5FF, 20'h0},
    '{CLS_BIT, 16'h0E7F, 16'h0000, 4'h5, 4'h9, 12'h07F, 20'h0},
    '{CLS_BIT, 16'h0D00, 16'h0000, 4'hA, 4'h9, 12'hA00, 20'h0},
    '{CLS_MOVE, 16'h0FFF, 16'hFABC, 4'h3, 4'h1, 12'hFFF, 20'h0},
    '{CLS_MOVE, 16'h0000, 16'h0123, 4'h3, 4'h1, 12'h000, 20'h0},
    '{CLS_LIT, 16'h00C3, 16'h0000, 4'h0, 4'h2, 12'h0, 20'h000C3},
    '{CLS_LIT12, 16'h000D, 16'h00E1, 4'h0, 4'h2, 12'h0, 20'h00DE1},
    '{CLS_GOTO, 16'h0012, 16'h0345, 4'h0, 4'h2, 12'h0, 20'h34512},
    '{CLS_CALL, 16'h0081, 16'h0FED, 4'h0, 4'h6, 12'h0, 20'hFED81},
    '{CLS_RET, 16'h0000, 16'h0000, 4'h0, 4'h4, 12'h0, 20'h0}};
  logic [31:0] tbl_exp [4] = '{32'h100, 32'h101, 32'h0FF, 32'h101};

  // ****************************************
  // clock, design and bus master
  // ****************************************
  // 25 MHz system clock
  always #20 clk_sys_i = ~clk_sys_i;
  ofd_decoder dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .eff_addr_o(eff_addr), .bit_mask_o(bit_mask), .result_to_acc_o(to_acc),
    .shadow_sel_o(shadow), .literal_o(literal), .busy_o(busy));
  ofd_ahb_master m_u (.clk_sys_i(clk_sys_i), .hready_i(hready),
    .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata), .tmo_o(tmo));

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    m_u.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input string nm, input logic [31:0] a,
                     input logic [31:0] e);
    logic [31:0] x;
    m_u.xfer(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask : rdc
  // loads an instruction, starts it and polls until idle
  task automatic ex(input ofd_class_t c, input logic [15:0] i0,
                    input logic [15:0] i1);
    logic [31:0] x;
    int n;
    wr(A_CLASS, {28'h0, c});
    wr(A_INSTR0, {16'h0, i0});
    wr(A_INSTR1, {16'h0, i1});
    wr(A_EXEC, 32'h1);
    @(negedge clk_sys_i);
    chk("busy", 32'h1, {31'h0, busy});
    n = 0;
    do begin
      m_u.xfer(1'b0, A_EXEC, 32'h0, x);
      n++;
    end while (x[0] !== 1'b0 && n < 20);
    if (x[0] !== 1'b0) begin
      err_count++;
      give_verdict();
    end
  endtask : ex
  task automatic rst_chk;
    chk("reset outs", {7'h0, 12'h0, 8'h01, 5'b10010},
        {7'h0, eff_addr, bit_mask, to_acc, shadow, busy, hready, hresp});
    chk("reset literal", 32'h0, {12'h0, literal});
    chk("reset rdata", 32'h0, hrdata);
  endtask : rst_chk

  // ****************************************
  // main sequence
  // ****************************************
  // a hung handshake ends the run
  initial begin
    wait (tmo === 1'b1);
    err_count++;
    give_verdict();
  end
  // overall run limit
  initial begin
    #4000000;
    err_count++;
    give_verdict();
  end
  // scenarios
  initial begin
    repeat (9) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_chk();
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    $display("test reset done");
    foreach (rows[i]) begin
      wr(A_CLASS, {28'h0, rows[i].cls});
      wr(A_INSTR0, {16'h0, rows[i].i0});
      wr(A_INSTR1, {16'h0, rows[i].i1});
      wr(A_BANK, {28'h0, rows[i].bk});
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      if (rows[i].chk[0]) chk("eff_addr", rows[i].ea, eff_addr);
      if (rows[i].chk[1]) chk("literal", rows[i].lit, literal);
      if (rows[i].chk[2]) chk("fast", rows[i].i0[0], shadow);
      if (rows[i].chk[3]) chk("mask_dest", {8'h01 << rows[i].i0[11:9],
        ~rows[i].i0[9]}, {bit_mask, to_acc});
      if (rows[i].cls == CLS_MOVE) rdc("faddr", A_FADDR, {4'h0,
        rows[i].i1[11:0], 4'h0, rows[i].ea});
    end
    $display("test field table done");
    wr(A_BANK, 32'h2);
    wr(A_ACC, 32'h0F);
    ex(CLS_STORE, 16'h0110, 16'h0);
    wr(A_ACC, 32'hF1);
    ex(CLS_BYTE, 16'h0110, 16'h0);
    rdc("acc", A_ACC, 32'h00);
    rdc("flags", A_FLAGS, 32'h07);
    wr(A_ACC, 32'h70);
    ex(CLS_BYTE, 16'h0310, 16'h0);
    rdc("acc", A_ACC, 32'h70);
    wr(A_ACC, 32'h01);
    ex(CLS_BYTE, 16'h0110, 16'h0);
    rdc("acc", A_ACC, 32'h80);
    rdc("flags", A_FLAGS, 32'h1A);
    ex(CLS_MOVE, 16'h0210, 16'h0345);
    wr(A_BANK, 32'h3);
    wr(A_ACC, 32'h0);
    ex(CLS_BYTE, 16'h0145, 16'h0);
    rdc("moved byte", A_ACC, 32'h7F);
    ex(CLS_BIT, 16'h0F45, 16'h0);
    wr(A_ACC, 32'h0);
    ex(CLS_BYTE, 16'h0145, 16'h0);
    rdc("bit set", A_ACC, 32'hFF);
    ex(CLS_LIT, 16'h00C3, 16'h0);
    rdc("literal acc", A_ACC, 32'hC3);
    wr(A_ACC, 32'h12);
    ex(CLS_MUL, 16'h0034, 16'h0);
    rdc("product", A_PROD, 32'h03A8);
    $display("test execute done");
    wr(A_TABLE_LATCH, 32'h1AB);
    rdc("table latch", A_TABLE_LATCH, 32'hAB);
    wr(A_TABLE_POINTER, 32'hFFFFFFFF);
    rdc("table ptr", A_TABLE_POINTER, 32'h1FFFFF);
    ex(CLS_TABLE, 16'h0001, 16'h0);
    rdc("table wrap", A_TABLE_POINTER, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(A_TABLE_POINTER, 32'h100);
      ex(CLS_TABLE, 16'(m), 16'h0);
      rdc("table mode", A_TABLE_POINTER, tbl_exp[m]);
    end
    $display("test table done");
    wr(A_LATH, 32'h34);
    wr(A_LATU, 32'hFF);
    rdc("upper latch", A_LATU, 32'h1F);
    wr(A_PC, 32'h56);
    rdc("pc load", A_PC, 32'h1F3456);
    ex(CLS_BRA, 16'h0400, 16'h0);
    rdc("pc branch", A_PC, 32'h1F2C58);
    ex(CLS_GOTO, 16'h0012, 16'h0345);
    rdc("pc goto", A_PC, 32'h068A24);
    wr(A_ACC, 32'h11);
    ex(CLS_CALL, 16'h0001, 16'h0);
    wr(A_ACC, 32'h44);
    ex(CLS_CALL, 16'h0000, 16'h0);
    wr(A_ACC, 32'h22);
    ex(CLS_RET, 16'h0001, 16'h0);
    rdc("shadow acc", A_ACC, 32'h11);
    rdc("pc return", A_PC, 32'h6);
    $display("test flow done");
    rdc("id high", A_ID_HIGH, {24'h0, PART_ID_UPPER});
    wr(A_ID_HIGH, 32'hFF);
    rdc("id high", A_ID_HIGH, {24'h0, PART_ID_UPPER});
    rdc("id low", A_ID_LOW, {24'h0, PART_ID_LOWER, PART_REV});
    rdc("unmapped", 32'h0000_0100, 32'h0);
    $display("test id done");
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    @(negedge clk_sys_i);
    rst_chk();
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rdc("acc after reset", A_ACC, 32'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule : operand_field_decoder_bench
